// File: hdl/capture_compare_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the capture/compare unit.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Definitions only.
`ifndef CAPTURE_COMPARE_DEFS_SVH
`define CAPTURE_COMPARE_DEFS_SVH

`define CC_ADDR_WIDTH      12
`define CC_OFS_CONTROL     10'h000
`define CC_OFS_RESULT_LOW  10'h001
`define CC_OFS_RESULT_HIGH 10'h002
`define CC_OFS_FLAGS       10'h003
`define CC_OFS_TIMER       10'h004

`define CC_MODE_LSB        0
`define CC_MODE_MSB        3
`define CC_DUTY_B0_POS     4
`define CC_DUTY_B1_POS     5
`define CC_FLAG_POS        0

`define CC_CONTROL_RESET   6'h00
`define CC_FLAG_RESET      1'b0
`define CC_TIMER_RESET     16'h0000
`define CC_RESULT_RESET    8'h00

`define CC_MODE_OFF        4'h0
`define CC_MODE_TOGGLE     4'h2
`define CC_MODE_FALL       4'h4
`define CC_MODE_RISE       4'h5
`define CC_MODE_RISE4      4'h6
`define CC_MODE_RISE16     4'h7
`define CC_MODE_SET        4'h8
`define CC_MODE_CLEAR      4'h9
`define CC_MODE_SOFT       4'hA
`define CC_MODE_SPECIAL    4'hB

`define CC_PRESCALE_LAST4  2'h3
`define CC_PRESCALE_LAST16 4'hF

`endif

// File: hdl/capture_compare_pkg.sv
// Purpose: Types shared by the capture/compare unit and its bench.
// Assumes: APB3 signalling without strobes.
// Notes:   Constants live in capture_compare_defs.svh.
`include "capture_compare_defs.svh"

package capture_compare_pkg;

  typedef struct packed {
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [`CC_ADDR_WIDTH-1:0] paddr;
    logic [31:0]               pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef enum logic [3:0] {
    CLASS_OFF     = 4'b0001,
    CLASS_CAPTURE = 4'b0010,
    CLASS_COMPARE = 4'b0100,
    CLASS_PWM     = 4'b1000
  } mode_class_type;

endpackage

// File: hdl/timer_capture_compare_unit.sv
// Purpose: Capture/compare unit with its 16-bit capture timer, reached over APB.
// Assumes: All inputs synchronous to sys_clk; timerTick is a one-cycle enable.
// Notes:   PWM waveform and A/D converter are outside; duty bits are only stored.
//
// Overview of operation
// RULE1 - Mode zero turns unit off, resets state.
// RULE2 - Software avoids reserved modes 0001, 0011.
// RULE3 - Mode 0010 toggles pin, sets flag.
// RULE4 - Modes 0100-0111 pick capture edge and prescale.
// RULE5 - Mode 1000 sets, 1001 clears pin, flag.
// RULE6 - Mode 1010 only sets the flag.
// RULE7 - Mode 1011 flags, resets timer, starts conversion.
// RULE8 - Modes 11xx PWM; bits 5-4 duty LSBs.
// RULE9 - Control bits 7-6 read zero; reset zero.
// RULE10 - Capture copies full timer into result pair.
// RULE11 - Capture sets flag; only software clears.
// RULE12 - New capture overwrites unread result.
// RULE13 - Capture watches pin level even driven.
// RULE14 - Software should make pin input for capture.
// RULE15 - Software clocks timer synchronously only.
// RULE16 - Mode change may raise false flag.
// RULE17 - Prescaler cleared when off or not capturing.
// RULE18 - Prescale switch keeps counter; clear control first.
// RULE19 - Sleep halts internally clocked timer only.
// RULE20 - Compare modes compare result with timer.
// RULE21 - Special event immediate; timer reset next tick.
// RULE22 - Clearing control forces compare latch low.
// RULE23 - Pin synchronised; one capture per edge.
// RULE24 - Result pair writable, reads without side effect.
`timescale 1ns/100ps
`include "capture_compare_defs.svh"

module timer_capture_compare_unit
  #(
    parameter int TIMER_WIDTH = 16
  )
  (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire capture_compare_pkg::apb_req_type  apbReq,
    output      capture_compare_pkg::apb_rsp_type  apbRsp,
    input  wire logic                              pinIn,
    output      logic                              pinOut,
    output      logic                              pinOe,
    input  wire logic                              timerTick,
    input  wire logic                              extClockSel,
    input  wire logic                              sleepMode,
    input  wire logic                              adcEnabled,
    output      logic                              adcStart,
    output      logic                              specialEvent,
    output      logic                              eventFlag
  );

  import capture_compare_pkg::*;

  if (TIMER_WIDTH != 16)
  begin : gen_width_check
    $error("The timer must be 16 bits wide.");
  end

  logic [5:0]             control;
  logic [7:0]             resultLow;
  logic [7:0]             resultHigh;
  logic [TIMER_WIDTH-1:0] captureTimer;
  logic [3:0]             prescaleCount;
  logic [2:0]             pinSync;
  logic                   compareLatch;
  logic                   matchSeen;
  logic                   resetPending;
  logic [31:0]            readData;
  logic [3:0]             unitMode;
  mode_class_type         modeClass;
  logic [9:0]             wordIndex;
  logic                   setupPhase;
  logic                   accessPhase;
  logic                   writeTaken;
  logic                   mapped;
  logic                   pinRose;
  logic                   pinFell;
  logic                   captureEvent;
  logic                   timerMatch;
  logic                   matchEvent;
  logic                   timerRun;
  logic                   controlZeroWrite;
  logic [5:0]             next_control;

  assign unitMode   = control[`CC_MODE_MSB:`CC_MODE_LSB];
  assign wordIndex  = apbReq.paddr[`CC_ADDR_WIDTH-1:2];
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign accessPhase = apbReq.psel & apbReq.penable;

  always_comb
  begin
    unique case (wordIndex)
      `CC_OFS_CONTROL,
      `CC_OFS_RESULT_LOW,
      `CC_OFS_RESULT_HIGH,
      `CC_OFS_FLAGS,
      `CC_OFS_TIMER:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  assign writeTaken = accessPhase & apbReq.pwrite & mapped;

  // Modes 0001 and 0011 have no function and behave like off.
  always_comb
  begin
    unique case (unitMode)
      `CC_MODE_FALL,
      `CC_MODE_RISE,
      `CC_MODE_RISE4,
      `CC_MODE_RISE16:
        modeClass = CLASS_CAPTURE; // [RULE4]
      `CC_MODE_TOGGLE,
      `CC_MODE_SET,
      `CC_MODE_CLEAR,
      `CC_MODE_SOFT,
      `CC_MODE_SPECIAL:
        modeClass = CLASS_COMPARE;
      4'hC,
      4'hD,
      4'hE,
      4'hF:
        modeClass = CLASS_PWM; // [RULE8]
      default:
        modeClass = CLASS_OFF; // [RULE1] [RULE2]
    endcase
  end

  // The register interface answers in the access phase with no wait state.
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = accessPhase & ~mapped;
  assign apbRsp.prdata  = readData;

  // Read data is latched in the setup cycle; reads have no side effects.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      readData <= 32'h0000_0000;
    end
    else if (setupPhase)
    begin
      unique case (wordIndex)
        `CC_OFS_CONTROL:
          readData <= {26'h000_0000, control}; // [RULE9]
        `CC_OFS_RESULT_LOW:
          readData <= {24'h00_0000, resultLow}; // [RULE24]
        `CC_OFS_RESULT_HIGH:
          readData <= {24'h00_0000, resultHigh}; // [RULE24]
        `CC_OFS_FLAGS:
          readData <= {31'h0000_0000, eventFlag};
        `CC_OFS_TIMER:
          readData <= {16'h0000, captureTimer};
        default:
          readData <= 32'h0000_0000;
      endcase
    end
  end

  assign next_control     = apbReq.pwdata[5:0];
  assign controlZeroWrite = writeTaken & (wordIndex == `CC_OFS_CONTROL) & (next_control == 6'h00);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      control <= `CC_CONTROL_RESET; // [RULE9]
    end
    else if (writeTaken && wordIndex == `CC_OFS_CONTROL)
    begin
      control <= next_control; // [RULE8] [RULE9]
    end
  end

  // Pin level is sampled whatever its direction, so port writes can capture.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinSync <= 3'b000;
    end
    else
    begin
      pinSync <= {pinSync[1:0], pinIn}; // [RULE13] [RULE23]
    end
  end

  assign pinRose = pinSync[1] & ~pinSync[2]; // [RULE23]
  assign pinFell = ~pinSync[1] & pinSync[2]; // [RULE23]

  // The prescaler keeps counting across prescale changes.
  always_ff @(posedge sys_clk)
  begin
    if (rst || modeClass != CLASS_CAPTURE)
    begin
      prescaleCount <= 4'h0; // [RULE17]
    end
    else if (pinRose)
    begin
      prescaleCount <= prescaleCount + 4'h1; // [RULE18]
    end
  end

  always_comb
  begin
    unique case (unitMode)
      `CC_MODE_FALL:
        captureEvent = pinFell; // [RULE4]
      `CC_MODE_RISE:
        captureEvent = pinRose; // [RULE4]
      `CC_MODE_RISE4:
        captureEvent = pinRose & (prescaleCount[1:0] == `CC_PRESCALE_LAST4); // [RULE4]
      `CC_MODE_RISE16:
        captureEvent = pinRose & (prescaleCount == `CC_PRESCALE_LAST16); // [RULE4]
      default:
        captureEvent = 1'b0;
    endcase
  end

  assign timerMatch = (modeClass == CLASS_COMPARE) && (captureTimer == {resultHigh, resultLow}); // [RULE20]

  always_ff @(posedge sys_clk)
  begin
    if (rst || modeClass != CLASS_COMPARE)
    begin
      matchSeen <= 1'b0; // [RULE1]
    end
    else
    begin
      matchSeen <= timerMatch;
    end
  end

  assign matchEvent   = timerMatch & ~matchSeen;
  assign specialEvent = timerMatch & (unitMode == `CC_MODE_SPECIAL); // [RULE21] [RULE7]
  assign adcStart     = matchEvent & (unitMode == `CC_MODE_SPECIAL) & adcEnabled; // [RULE7]

  // Result pair: a capture wins over a software write in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      resultLow  <= `CC_RESULT_RESET;
      resultHigh <= `CC_RESULT_RESET;
    end
    else if (captureEvent)
    begin
      resultLow  <= captureTimer[7:0]; // [RULE10] [RULE12]
      resultHigh <= captureTimer[15:8]; // [RULE10] [RULE12]
    end
    else if (writeTaken)
    begin
      if (wordIndex == `CC_OFS_RESULT_LOW)
      begin
        resultLow <= apbReq.pwdata[7:0]; // [RULE24]
      end
      if (wordIndex == `CC_OFS_RESULT_HIGH)
      begin
        resultHigh <= apbReq.pwdata[7:0]; // [RULE24]
      end
    end
  end

  // A mode change can create a spurious event; software clears the flag after it.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      eventFlag <= `CC_FLAG_RESET;
    end
    else if (captureEvent || matchEvent)
    begin
      eventFlag <= 1'b1; // [RULE11] [RULE3] [RULE5] [RULE6] [RULE7] [RULE16]
    end
    else if (writeTaken && wordIndex == `CC_OFS_FLAGS && apbReq.pwdata[`CC_FLAG_POS])
    begin
      eventFlag <= 1'b0; // [RULE11]
    end
  end

  // Compare output latch drives the pin only in the pin-controlling modes.
  always_ff @(posedge sys_clk)
  begin
    if (rst || modeClass == CLASS_OFF || controlZeroWrite)
    begin
      compareLatch <= 1'b0; // [RULE1] [RULE22]
    end
    else if (matchEvent)
    begin
      unique case (unitMode)
        `CC_MODE_TOGGLE:
          compareLatch <= ~compareLatch; // [RULE3]
        `CC_MODE_SET:
          compareLatch <= 1'b1; // [RULE5]
        `CC_MODE_CLEAR:
          compareLatch <= 1'b0; // [RULE5]
        default:
          compareLatch <= compareLatch; // [RULE6] [RULE7]
      endcase
    end
  end

  assign pinOut = compareLatch;
  assign pinOe  = (unitMode == `CC_MODE_TOGGLE) | (unitMode == `CC_MODE_SET) | (unitMode == `CC_MODE_CLEAR);

  // An internally clocked timer halts in sleep and resumes from its value.
  assign timerRun = timerTick & (extClockSel | ~sleepMode); // [RULE19] [RULE15]

  // The special event reset waits for the next tick and is dropped if the match goes away.
  always_ff @(posedge sys_clk)
  begin
    if (rst || unitMode != `CC_MODE_SPECIAL)
    begin
      resetPending <= 1'b0;
    end
    else
    begin
      resetPending <= specialEvent; // [RULE21]
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      captureTimer <= `CC_TIMER_RESET;
    end
    else if (writeTaken && wordIndex == `CC_OFS_TIMER)
    begin
      captureTimer <= apbReq.pwdata[15:0];
    end
    else if (timerRun)
    begin
      if (resetPending && specialEvent)
      begin
        captureTimer <= `CC_TIMER_RESET; // [RULE7] [RULE21]
      end
      else
      begin
        captureTimer <= captureTimer + 16'h0001;
      end
    end
  end

endmodule

// File: tb/pin_event_source.sv
// Purpose: Drives the event pin from outside the unit.
// Assumes: Each level is held for three clocks or more.
// Notes:   The wire follows the unit while it drives.
`timescale 1ns/100ps
module pin_event_source
  (
    input  wire logic sys_clk,
    input  wire logic pinOut,
    input  wire logic pinOe,
    output      logic pinLevel
  );
  logic extLevel = 1'b0;
  assign pinLevel = pinOe ? pinOut : extLevel;
  task automatic pulse(input int n);
    repeat (n)
    begin
      extLevel <= 1'b1;
      repeat (3) @(posedge sys_clk);
      extLevel <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule

// File: tb/tb_timer_capture_compare_unit.sv
// Purpose: Self-checking bench for the capture/compare unit.
// Assumes: The timer stands still while timerTick is low.
// Notes:   Pin edges come from the pin_event_source model.
`timescale 1ns/100ps
module tb_timer_capture_compare_unit;
  import capture_compare_pkg::*;
  localparam logic [11:0] CTL = 12'h000;
  localparam logic [11:0] RLO = 12'h004;
  localparam logic [11:0] RHI = 12'h008;
  localparam logic [11:0] FLG = 12'h00C;
  localparam logic [11:0] TMR = 12'h010;
  logic        sys_clk;
  logic        rst;
  apb_req_type apbReq;
  apb_rsp_type apbRsp;
  logic        pinIn;
  logic        pinOut;
  logic        pinOe;
  logic        timerTick;
  logic        extClockSel;
  logic        sleepMode;
  logic        adcEnabled;
  logic        adcStart;
  logic        specialEvent;
  logic        eventFlag;
  int          adcCount = 0;
  logic [31:0] rdData;
  logic        rdErr;
  int          errCount = 0;
  int          numChecks = 0;
  logic [3:0]  modes [6] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'hA, 4'hB};
  logic [1:0]  pins [6] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0};
  timer_capture_compare_unit u_timer_capture_compare_unit
  (
    .sys_clk(sys_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .timerTick(timerTick), .extClockSel(extClockSel), .sleepMode(sleepMode),
    .adcEnabled(adcEnabled), .adcStart(adcStart), .specialEvent(specialEvent), .eventFlag(eventFlag)
  );
  always @(posedge sys_clk)
    if (adcStart === 1'b1)
      adcCount <= adcCount + 1;
  pin_event_source u_pin_event_source
  (
    .sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinIn)
  );
  task automatic final_report;
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    @(posedge sys_clk);
    while (apbRsp.pready !== 1'b1)
      @(posedge sys_clk);
    rdData = apbRsp.prdata;
    rdErr  = apbRsp.pslverr;
    apbReq <= '0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdData, exp);
  endtask
  task automatic t_regs;
    rdchk(CTL, 32'h0);
    wr(CTL, 32'hFF);
    rdchk(CTL, 32'h3F);
    wr(CTL, 32'h0);
    wr(RLO, 32'hA5);
    rdchk(RLO, 32'hA5);
    rdchk(RLO, 32'hA5);
    rdchk(12'h020, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    $display("regs done");
  endtask
  task automatic t_capture;
    wr(TMR, 32'h1234);
    wr(CTL, 32'h5);
    wr(FLG, 32'h1);
    u_pin_event_source.pulse(1);
    rdchk(RLO, 32'h34);
    rdchk(RHI, 32'h12);
    rdchk(FLG, 32'h1);
    rdchk(FLG, 32'h1);
    wr(TMR, 32'hBEEF);
    u_pin_event_source.pulse(1);
    rdchk(RHI, 32'hBE);
    rdchk(RLO, 32'hEF);
    wr(FLG, 32'h1);
    rdchk(FLG, 32'h0);
    $display("capture done");
  endtask
  task automatic t_prescale;
    int n [4] = '{1, 1, 4, 16};
    for (int m = 0; m < 4; m++)
    begin
      wr(CTL, 32'h0);
      wr(CTL, 32'h4 + 32'(m));
      wr(FLG, 32'h1);
      u_pin_event_source.pulse(n[m] - 1);
      rdchk(FLG, 32'h0);
      u_pin_event_source.pulse(1);
      rdchk(FLG, 32'h1);
    end
    wr(CTL, 32'h0);
    wr(CTL, 32'h6);
    wr(FLG, 32'h1);
    u_pin_event_source.pulse(2);
    wr(CTL, 32'h0);
    wr(CTL, 32'h6);
    u_pin_event_source.pulse(3);
    rdchk(FLG, 32'h0);
    $display("prescale done");
  endtask
  task automatic t_compare;
    wr(RLO, 32'h10);
    wr(RHI, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(TMR, 32'h0);
      wr(CTL, {28'h0, modes[i]});
      wr(FLG, 32'h1);
      wr(TMR, 32'h10);
      @(negedge sys_clk);
      chk({30'h0, pinOe, pinOut}, {30'h0, pins[i]});
      chk({31'h0, specialEvent}, {31'h0, modes[i] == 4'hB});
      chk({31'h0, eventFlag}, 32'h1);
      @(posedge sys_clk);
      rdchk(FLG, 32'h1);
    end
    chk(32'(adcCount), 32'h1);
    rdchk(TMR, 32'h10);
    timerTick <= 1'b1;
    @(posedge sys_clk);
    timerTick <= 1'b0;
    rdchk(TMR, 32'h0);
    wr(CTL, 32'h8);
    wr(TMR, 32'h10);
    @(negedge sys_clk);
    chk({30'h0, pinOe, pinOut}, 32'h3);
    @(posedge sys_clk);
    wr(CTL, 32'h0);
    @(negedge sys_clk);
    chk({30'h0, pinOe, pinOut}, 32'h0);
    @(posedge sys_clk);
    $display("compare done");
  endtask
  task automatic t_sleep;
    logic [31:0] expv [2] = '{32'h0, 32'h5};
    for (int i = 0; i < 2; i++)
    begin
      wr(TMR, 32'h0);
      extClockSel <= i[0];
      sleepMode   <= 1'b1;
      timerTick   <= 1'b1;
      repeat (5) @(posedge sys_clk);
      timerTick   <= 1'b0;
      sleepMode   <= 1'b0;
      rdchk(TMR, expv[i]);
    end
    $display("sleep done");
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    errCount++;
    final_report();
  end
  initial
  begin
    rst         = 1'b1;
    apbReq      = '0;
    timerTick   = 1'b0;
    extClockSel = 1'b0;
    sleepMode   = 1'b0;
    adcEnabled  = 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_capture();
    t_prescale();
    t_compare();
    t_sleep();
    final_report();
  end
endmodule
bind timer_capture_compare_unit timer_capture_compare_unit_assertions
  #(.TIMER_WIDTH(TIMER_WIDTH)) u_timer_capture_compare_unit_assertions
  (
    .sys_clk(sys_clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .timerTick(timerTick), .extClockSel(extClockSel), .sleepMode(sleepMode),
    .adcEnabled(adcEnabled), .adcStart(adcStart), .specialEvent(specialEvent), .eventFlag(eventFlag)
  );

// File: tb/timer_capture_compare_unit_assertions.sv
// Purpose: Port-level assertions for the capture/compare unit.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Flag register sits at byte address 0x0C.
`timescale 1ns/100ps
module timer_capture_compare_unit_assertions
  #(
    parameter int TIMER_WIDTH = 16
  )
  (
    input wire logic                             sys_clk,
    input wire logic                             rst,
    input wire capture_compare_pkg::apb_req_type apbReq,
    input wire capture_compare_pkg::apb_rsp_type apbRsp,
    input wire logic                             pinIn,
    input wire logic                             pinOut,
    input wire logic                             pinOe,
    input wire logic                             timerTick,
    input wire logic                             extClockSel,
    input wire logic                             sleepMode,
    input wire logic                             adcEnabled,
    input wire logic                             adcStart,
    input wire logic                             specialEvent,
    input wire logic                             eventFlag
  );
  import capture_compare_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic access;
  logic ctlWr;
  logic flagClr;
  assign access  = apbReq.psel && apbReq.penable;
  assign ctlWr   = access && apbReq.pwrite && apbReq.paddr == 12'h000;
  assign flagClr = access && apbReq.pwrite && apbReq.paddr == 12'h00C && apbReq.pwdata[0];
  sequence s_trigger;
    adcStart ##1 eventFlag;
  endsequence
  a_ready_access: assert property (access |-> apbRsp.pready)
    else $error("access without ready");
  a_error_access: assert property (apbRsp.pslverr |-> access)
    else $error("error outside access");
  a_adc_match: assert property (adcStart |-> specialEvent && adcEnabled)
    else $error("start without match");
  a_adc_flag: assert property (adcStart |-> s_trigger)
    else $error("trigger left flag clear");
  a_adc_once: assert property (adcStart |=> !adcStart)
    else $error("start longer than a pulse");
  a_special_quiet: assert property (specialEvent |-> !pinOe)
    else $error("pin driven in trigger mode");
  a_flag_sticky: assert property ($fell(eventFlag) && !$past(rst) |-> $past(flagClr))
    else $error("flag cleared by hardware");
  a_oe_follows: assert property ($changed(pinOe) && !$past(rst) |-> $past(ctlWr))
    else $error("drive changed without write");
  a_pin_cause: assert property ($changed(pinOut) && !$past(rst) |-> $past(pinOe) || $past(ctlWr))
    else $error("pin moved without cause");
endmodule
